// *** pkg/sspw_defs.svh ***
`ifndef SSPW_DEFS_SVH
`define SSPW_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define SSPW_CW        16
`define SSPW_DTW       8
`define SSPW_AW        12
`define SSPW_IW        14

// ----------------------------------------
// timing
// ----------------------------------------
`define SSPW_CLK_MHZ     125
`define SSPW_CLK_HZ      125000000
`define SSPW_CARRIER_HZ  10000
`define SSPW_PER_CYC     (`SSPW_CLK_HZ / (2 * `SSPW_CARRIER_HZ))
`define SSPW_DEAD_NS     800
`define SSPW_DEAD_CYC    ((`SSPW_DEAD_NS * `SSPW_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// values
// ----------------------------------------
`define SSPW_ADC_MID     14'h0800
`define SSPW_SCAN_ALL    3'h7
`define SSPW_SCAN_NONE   3'h0

`endif

// *** pkg/sspw_pkg.sv ***
`include "sspw_defs.svh"

package sspw_pkg;

  // compare set: three phase compares and the two active-state durations
  typedef struct packed {
    logic [`SSPW_CW-1:0] a;
    logic [`SSPW_CW-1:0] b;
    logic [`SSPW_CW-1:0] c;
    logic [`SSPW_CW-1:0] t1;
    logic [`SSPW_CW-1:0] t2;
  } sspw_shd_t;

  // one phase gate pair
  typedef struct packed {
    logic hs;
    logic ls;
  } sspw_gate_t;

endpackage

// *** core/sspw_phase.sv ***
`timescale 1ns/1ps

module sspw_phase #(
  parameter int CW  = 16,
  parameter int DTW = 8
) (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic [CW-1:0]  cnt,
  input  wire logic [CW-1:0]  cmp,
  input  wire logic           en,
  input  wire logic [DTW-1:0] dead,
  output sspw_pkg::sspw_gate_t gate
);

  logic           want_q;
  logic           want_d;
  logic [DTW-1:0] dt_q;
  logic [DTW-1:0] dt_d;
  sspw_pkg::sspw_gate_t gate_q;
  sspw_pkg::sspw_gate_t gate_d;

  // ----------------------------------------
  // complementary pair with dead band
  // ----------------------------------------
  always_comb
  begin
    want_d = en & (cnt < cmp);
    dt_d   = dt_q;
    gate_d = '0;
    if (want_d != want_q)
    begin
      dt_d = dead;
    end
    else if (dt_q != '0)
    begin
      dt_d = dt_q - 1'b1;
    end
    else
    begin
      gate_d.hs = want_q & en;
      gate_d.ls = ~want_q & en;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      want_q <= 1'b0;
      dt_q   <= '0;
      gate_q <= '0;
    end
    else
    begin
      want_q <= want_d;
      dt_q   <= dt_d;
      gate_q <= gate_d;
    end
  end

  assign gate = gate_q;

  a_pair_exclusive: assert property (@(posedge clk) disable iff (!rst_b) !(gate_q.hs && gate_q.ls))
    else $error("high and low side on together");

endmodule

// *** core/sspw_top.sv ***
`timescale 1ns/1ps
`include "sspw_defs.svh"

module sspw_top #(
  parameter int PER  = `SSPW_PER_CYC,
  parameter int DEAD = `SSPW_DEAD_CYC
) (
  input  wire logic                   CLK,
  input  wire logic                   RST_B,
  input  wire logic                   RUN_PIN,
  input  wire logic                   OC_CMP_PIN,
  input  wire logic                   FAULT_CLR,
  input  wire logic                   CMP_WR,
  input  wire sspw_pkg::sspw_shd_t    CMP_IN,
  input  wire logic                   ADC_DONE,
  input  wire logic [`SSPW_AW-1:0]    ADC_DATA,
  output logic [2:0]                  HS,
  output logic [2:0]                  LS,
  output logic                        PWM_IRQ,
  output logic                        OC_IRQ,
  output logic                        FAULT,
  output logic                        ADC_TRIG,
  output logic                        ADC_TAG,
  output logic [2:0]                  ADC_SCAN,
  output logic signed [`SSPW_IW-1:0]  I_FIRST,
  output logic signed [`SSPW_IW-1:0]  I_SECOND,
  output logic signed [`SSPW_IW-1:0]  I_THIRD
);

  localparam logic [`SSPW_CW-1:0]  PER_V  = `SSPW_CW'(PER);
  localparam logic [`SSPW_DTW-1:0] DEAD_V = `SSPW_DTW'(DEAD);

  // ----------------------------------------
  // pin synchronisers and fault latch
  // ----------------------------------------
  logic [1:0] run_sync_q;
  logic [1:0] oc_sync_q;
  logic       oc_prev_q;
  logic       fault_q;
  logic       fault_d;
  logic       oc_irq_q;
  logic       oc_irq_d;
  logic       en;

  always_comb
  begin
    oc_irq_d = oc_sync_q[1] & ~oc_prev_q;
    fault_d  = fault_q;
    if (FAULT_CLR)
    begin
      fault_d = 1'b0;
    end
    if (oc_sync_q[1])
    begin
      fault_d = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      run_sync_q <= '0;
      oc_sync_q  <= '0;
      oc_prev_q  <= 1'b0;
      fault_q    <= 1'b0;
      oc_irq_q   <= 1'b0;
    end
    else
    begin
      run_sync_q <= {run_sync_q[0], RUN_PIN};
      oc_sync_q  <= {oc_sync_q[0], OC_CMP_PIN};
      oc_prev_q  <= oc_sync_q[1];
      fault_q    <= fault_d;
      oc_irq_q   <= oc_irq_d;
    end
  end

  assign en = run_sync_q[1] & ~fault_q;

  // ----------------------------------------
  // up/down carrier, shadow and active compares
  // ----------------------------------------
  logic [`SSPW_CW-1:0] cnt_q;
  logic [`SSPW_CW-1:0] cnt_d;
  logic                up_q;
  logic                up_d;
  logic                top;
  logic                bot;
  logic                upd;
  sspw_pkg::sspw_shd_t shd_q;
  sspw_pkg::sspw_shd_t shd_d;
  sspw_pkg::sspw_shd_t act_q;
  sspw_pkg::sspw_shd_t act_d;

  assign top = en & up_q & (cnt_q == PER_V);
  assign bot = en & ~up_q & (cnt_q == '0);
  assign upd = top | bot;

  always_comb
  begin
    cnt_d = cnt_q;
    up_d  = up_q;
    shd_d = CMP_WR ? CMP_IN : shd_q;
    act_d = upd ? shd_q : act_q;
    if (!run_sync_q[1])
    begin
      cnt_d = '0;
      up_d  = 1'b1;
    end
    else if (en)
    begin
      if (top)
      begin
        up_d  = 1'b0;
        cnt_d = cnt_q - 1'b1;
      end
      else if (bot)
      begin
        up_d  = 1'b1;
        cnt_d = cnt_q + 1'b1;
      end
      else
      begin
        cnt_d = up_q ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cnt_q <= '0;
      up_q  <= 1'b1;
      shd_q <= '0;
      act_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      up_q  <= up_d;
      shd_q <= shd_d;
      act_q <= act_d;
    end
  end

  // ----------------------------------------
  // phase pairs
  // ----------------------------------------
  sspw_pkg::sspw_gate_t gate_a;
  sspw_pkg::sspw_gate_t gate_b;
  sspw_pkg::sspw_gate_t gate_c;

  sspw_phase #(.CW(`SSPW_CW), .DTW(`SSPW_DTW)) u_ph_a (.clk(CLK), .rst_b(RST_B), .cnt(cnt_q),
    .cmp(act_q.a), .en(en), .dead(DEAD_V), .gate(gate_a));
  sspw_phase #(.CW(`SSPW_CW), .DTW(`SSPW_DTW)) u_ph_b (.clk(CLK), .rst_b(RST_B), .cnt(cnt_q),
    .cmp(act_q.b), .en(en), .dead(DEAD_V), .gate(gate_b));
  sspw_phase #(.CW(`SSPW_CW), .DTW(`SSPW_DTW)) u_ph_c (.clk(CLK), .rst_b(RST_B), .cnt(cnt_q),
    .cmp(act_q.c), .en(en), .dead(DEAD_V), .gate(gate_c));

  assign HS = {gate_c.hs, gate_b.hs, gate_a.hs};
  assign LS = {gate_c.ls, gate_b.ls, gate_a.ls};

  // ----------------------------------------
  // delay timer and adc trigger
  // ----------------------------------------
  logic                dly_run_q;
  logic                dly_run_d;
  logic [`SSPW_CW-1:0] dly_cnt_q;
  logic [`SSPW_CW-1:0] dly_cnt_d;
  logic [`SSPW_CW-1:0] dly_cmp_q;
  logic [`SSPW_CW-1:0] dly_cmp_d;
  logic                cur_pend_q;
  logic                cur_pend_d;
  logic                match;
  logic                zero_vec;
  logic                trig_q;
  logic                trig_d;
  logic                tag_q;
  logic                tag_d;
  logic                irq_q;
  logic [2:0]          scan_q;
  logic [2:0]          scan_d;

  assign match    = en & dly_run_q & (dly_cnt_q == dly_cmp_q);
  assign zero_vec = (HS == 3'h0) | (HS == 3'h7);

  always_comb
  begin
    dly_run_d  = dly_run_q & en;
    dly_cnt_d  = dly_cnt_q;
    dly_cmp_d  = dly_cmp_q;
    cur_pend_d = cur_pend_q;
    if (match)
    begin
      dly_run_d = 1'b0;
    end
    else if (dly_run_q)
    begin
      dly_cnt_d = dly_cnt_q + 1'b1;
    end
    if (bot)
    begin
      dly_run_d = 1'b1;
      dly_cnt_d = '0;
    end
    if (ADC_DONE && cur_pend_q)
    begin
      cur_pend_d = 1'b0;
      dly_cmp_d  = act_q.t2 >> 1;
    end
    if (top)
    begin
      dly_cmp_d = shd_q.t1 >> 1;
    end
    trig_d = top | (match & ~zero_vec);
    tag_d  = match & ~zero_vec;
    scan_d = trig_d ? `SSPW_SCAN_ALL : `SSPW_SCAN_NONE;
    if (tag_d)
    begin
      cur_pend_d = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dly_run_q  <= 1'b0;
      dly_cnt_q  <= '0;
      dly_cmp_q  <= '0;
      cur_pend_q <= 1'b0;
      trig_q     <= 1'b0;
      tag_q      <= 1'b0;
      irq_q      <= 1'b0;
      scan_q     <= `SSPW_SCAN_NONE;
    end
    else
    begin
      dly_run_q  <= dly_run_d;
      dly_cnt_q  <= dly_cnt_d;
      dly_cmp_q  <= dly_cmp_d;
      cur_pend_q <= cur_pend_d;
      trig_q     <= trig_d;
      tag_q      <= tag_d;
      irq_q      <= upd;
      scan_q     <= scan_d;
    end
  end

  // ----------------------------------------
  // bus current capture and reconstruction
  // ----------------------------------------
  logic                       smp_idx_q;
  logic                       smp_idx_d;
  logic signed [`SSPW_IW-1:0] i1_q;
  logic signed [`SSPW_IW-1:0] i1_d;
  logic signed [`SSPW_IW-1:0] i2_q;
  logic signed [`SSPW_IW-1:0] i2_d;
  logic signed [`SSPW_IW-1:0] i3_q;
  logic signed [`SSPW_IW-1:0] i3_d;
  logic signed [`SSPW_IW-1:0] smp;

  assign smp = $signed({2'b00, ADC_DATA}) - $signed(`SSPW_ADC_MID);

  always_comb
  begin
    smp_idx_d = smp_idx_q;
    i1_d      = i1_q;
    i2_d      = i2_q;
    i3_d      = i3_q;
    if (ADC_DONE && cur_pend_q)
    begin
      smp_idx_d = ~smp_idx_q;
      if (!smp_idx_q)
      begin
        i1_d = smp;
      end
      else
      begin
        i2_d = smp;
        i3_d = -(i1_q + smp);
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      smp_idx_q <= 1'b0;
      i1_q      <= '0;
      i2_q      <= '0;
      i3_q      <= '0;
    end
    else
    begin
      smp_idx_q <= smp_idx_d;
      i1_q      <= i1_d;
      i2_q      <= i2_d;
      i3_q      <= i3_d;
    end
  end

  assign PWM_IRQ  = irq_q;
  assign OC_IRQ   = oc_irq_q;
  assign FAULT    = fault_q;
  assign ADC_TRIG = trig_q;
  assign ADC_TAG  = tag_q;
  assign ADC_SCAN = scan_q;
  assign I_FIRST  = i1_q;
  assign I_SECOND = i2_q;
  assign I_THIRD  = i3_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_gate_exclusive: assert property ((HS & LS) == 3'h0)
    else $error("shoot-through on a phase");
  a_fault_kills: assert property ((fault_q || !run_sync_q[1]) |=> (HS == 3'h0) && (LS == 3'h0))
    else $error("outputs alive while disabled");
  a_irq_events: assert property (upd |=> PWM_IRQ ##1 !PWM_IRQ)
    else $error("pwm interrupt missing on event");
  a_swap_load: assert property (upd |=> act_q == $past(shd_q))
    else $error("active compares not swapped");
  a_swap_hold: assert property (!upd |=> $stable(act_q))
    else $error("active compares changed off strobe");
  a_t1_load: assert property (top |=> dly_cmp_q == ($past(shd_q.t1) >> 1))
    else $error("delay compare not T1/2");
  a_t2_load: assert property (ADC_DONE && cur_pend_q && !top |=> dly_cmp_q == ($past(act_q.t2) >> 1))
    else $error("delay compare not T2/2");
  a_bot_start: assert property (bot |=> dly_run_q && dly_cnt_q == '0)
    else $error("delay timer not started");
  a_top_trig: assert property (top |=> ADC_TRIG && ADC_SCAN == `SSPW_SCAN_ALL)
    else $error("no trigger on top event");
  a_mid_trig: assert property (match && !zero_vec |=> ADC_TRIG && ADC_TAG)
    else $error("no trigger on delay match");
  a_zero_skip: assert property (match && zero_vec |=> !ADC_TAG)
    else $error("current sampled in zero vector");
  a_third_sum: assert property (ADC_DONE && cur_pend_q && smp_idx_q |=> I_THIRD == -(I_FIRST + I_SECOND))
    else $error("third current wrong");

  // helper: a top event seen and no bottom event since
  logic top_seen_q;
  logic top_seen_d;

  assign top_seen_d = top | (top_seen_q & ~bot);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      top_seen_q <= 1'b0;
    end
    else
    begin
      top_seen_q <= top_seen_d;
    end
  end

  c_top_event: cover property (bot && top_seen_q);
  c_mid_sample: cover property (ADC_TRIG && ADC_TAG);
  c_fault_trip: cover property (OC_IRQ);

endmodule

// *** bench/sspw_drv_model.sv ***
`timescale 1ns/1ps

module sspw_drv_model (
  input  wire logic        clk,
  input  wire logic        run_req,
  input  wire logic        oc_req,
  input  wire logic        adc_trig,
  input  wire logic        adc_tag,
  input  wire logic [31:0] lat,
  output logic             run_pin,
  output logic             oc_pin,
  output logic             adc_done,
  output logic             adc_cur,
  output logic [11:0]      adc_data
);
  integer      seed = 32'haac1;
  logic [11:0] last = 12'h000;

  // ------
  // switch, comparator
  // ------
  assign run_pin = run_req;
  assign oc_pin  = oc_req;

  // ------
  // converter: scan ends lat cycles after trigger
  // ------
  task automatic conv(input logic tag);
    repeat (lat) @(posedge clk);
    #1;
    last     = 12'($random(seed));
    adc_done = 1'b1;
    adc_cur  = tag;
    adc_data = last;
    @(posedge clk);
    #1;
    adc_done = 1'b0;
    adc_cur  = 1'b0;
    adc_data = ~last;
  endtask

  initial
  begin
    adc_done = 1'b0;
    adc_cur  = 1'b0;
    adc_data = 12'h000;
  end

  always @(negedge clk)
    if (adc_trig === 1'b1)
      fork
        conv(adc_tag);
      join_none
endmodule

// *** bench/sspw_top_tb.sv ***
`timescale 1ns/1ps
`include "sspw_defs.svh"

module sspw_top_tb;
  logic                clk;
  logic                rst_b;
  logic                run_req;
  logic                oc_req;
  logic                run_pin;
  logic                oc_pin;
  logic                fault_clr;
  logic                cmp_wr;
  sspw_pkg::sspw_shd_t cmp_in;
  int                  lat;
  logic                adc_done;
  logic                adc_cur;
  logic [11:0]         adc_data;
  logic [2:0]          hs;
  logic [2:0]          ls;
  logic                pwm_irq;
  logic                oc_irq;
  logic                fault;
  logic                adc_trig;
  logic                adc_tag;
  logic [2:0]          adc_scan;
  logic signed [13:0]  i_first;
  logic signed [13:0]  i_second;
  logic signed [13:0]  i_third;
  int                  n_errors = 0;
  int                  n_compared = 0;
  int                  cyc = 0;
  int                  n_irq = 0;
  int                  n_t0 = 0;
  int                  n_t1 = 0;
  int                  top_c = 0;
  int                  exp_dly = 0;
  int                  di;
  int                  d0;
  int                  d1;
  logic                chk_dly = 1'b0;
  logic                alt = 1'b0;
  logic [2:0]          seen_hs = 3'h0;
  logic [2:0]          seen_ls = 3'h0;
  logic [11:0]         d;
  logic signed [13:0]  e_v;
  logic signed [13:0]  f_v;
  logic [11:0]         exp_q[$];
  integer              seed = 32'haac1;

  sspw_top #(.PER(40), .DEAD(3)) i_sspw_top (
    .CLK(clk), .RST_B(rst_b), .RUN_PIN(run_pin), .OC_CMP_PIN(oc_pin), .FAULT_CLR(fault_clr),
    .CMP_WR(cmp_wr), .CMP_IN(cmp_in), .ADC_DONE(adc_done), .ADC_DATA(adc_data), .HS(hs), .LS(ls),
    .PWM_IRQ(pwm_irq), .OC_IRQ(oc_irq), .FAULT(fault), .ADC_TRIG(adc_trig), .ADC_TAG(adc_tag),
    .ADC_SCAN(adc_scan), .I_FIRST(i_first), .I_SECOND(i_second), .I_THIRD(i_third));

  sspw_drv_model i_sspw_drv_model (
    .clk(clk), .run_req(run_req), .oc_req(oc_req), .adc_trig(adc_trig), .adc_tag(adc_tag),
    .lat(lat), .run_pin(run_pin), .oc_pin(oc_pin), .adc_done(adc_done), .adc_cur(adc_cur),
    .adc_data(adc_data));

  // ------
  // tasks
  // ------
  task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_n(input string nm, input int e, input int g);
    n_compared++;
    if (g != e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic set_cmp(input logic [15:0] a, b, c, t1, t2);
    @(posedge clk);
    #1;
    cmp_wr = 1'b1;
    cmp_in = {a, b, c, t1, t2};
    @(posedge clk);
    #1;
    cmp_wr = 1'b0;
  endtask

  task automatic cnt_win(input int n, output int wi, output int w0, output int w1);
    int a0;
    int b0;
    int c0;
    a0 = n_irq;
    b0 = n_t0;
    c0 = n_t1;
    repeat (n) @(posedge clk);
    #1;
    wi = n_irq - a0;
    w0 = n_t0 - b0;
    w1 = n_t1 - c0;
  endtask

  function automatic logic [15:0] rv();
    return 16'($unsigned($random(seed)) % 41);
  endfunction

  // ------
  // watcher
  // ------
  always @(negedge clk)
    if (rst_b)
    begin
      cyc++;
      chk_v("gate_overlap", 16'h0000, {13'h0, hs & ls});
      chk_v("adc_scan", {13'h0, adc_trig ? `SSPW_SCAN_ALL : `SSPW_SCAN_NONE}, {13'h0, adc_scan});
      seen_hs |= hs;
      seen_ls |= ls;
      if (pwm_irq === 1'b1)
        n_irq++;
      if (adc_trig === 1'b1 && adc_tag === 1'b0)
      begin
        n_t0++;
        top_c = cyc;
      end
      if (adc_trig === 1'b1 && adc_tag === 1'b1)
      begin
        n_t1++;
        if (chk_dly)
          chk_n("trig_delay", exp_dly, cyc - top_c);
      end
      if (exp_q.size() > 0)
      begin
        d = exp_q.pop_front();
        e_v = {2'b00, d} - 14'h0800;
        if (!alt)
          chk_v("i_first", 16'(e_v), 16'(i_first));
        else
        begin
          chk_v("i_second", 16'(e_v), 16'(i_second));
          chk_v("i_third", 16'(-(f_v + e_v)), 16'(i_third));
        end
        f_v = e_v;
        alt = ~alt;
      end
      if (adc_done === 1'b1 && adc_cur === 1'b1)
        exp_q.push_back(adc_data);
    end

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #(20000 * 8);
    n_errors++;
    results();
  end

  // ------
  // scenarios
  // ------
  initial
  begin
    rst_b = 1'b0;
    run_req = 1'b0;
    oc_req = 1'b0;
    fault_clr = 1'b0;
    cmp_wr = 1'b0;
    cmp_in = '0;
    lat = 4;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    run_req = 1'b1;
    set_cmp(16'h001e, 16'h0014, 16'h000a, 16'h001e, 16'h0028);
    repeat (200) @(posedge clk);
    exp_dly = 56;
    chk_dly = 1'b1;
    cnt_win(160, di, d0, d1);
    chk_n("irq_count", 4, di);
    chk_n("top_trig", 2, d0);
    chk_n("cur_trig", 2, d1);
    chk_v("hs_seen", 16'h0007, {13'h0, seen_hs});
    chk_v("ls_seen", 16'h0007, {13'h0, seen_ls});
    chk_dly = 1'b0;
    lat = 30;
    repeat (240) @(posedge clk);
    exp_dly = 61;
    chk_dly = 1'b1;
    cnt_win(160, di, d0, d1);
    chk_n("cur_trig", 2, d1);
    chk_dly = 1'b0;
    for (int k = 0; k < 200 && !(adc_done === 1'b1 && adc_cur === 1'b1); k++)
      @(negedge clk);
    lat = 4;
    repeat (160) @(posedge clk);
    for (int k = 0; k < 100 && !(adc_trig === 1'b1 && adc_tag === 1'b0); k++)
      @(negedge clk);
    set_cmp(16'h0000, 16'h0000, 16'h0000, 16'h001e, 16'h0028);
    seen_hs = 3'h0;
    repeat (30) @(posedge clk);
    chk_v("shadow_hold", 16'h0001, {15'h0, seen_hs[0]});
    repeat (15) @(posedge clk);
    seen_hs = 3'h0;
    repeat (30) @(posedge clk);
    chk_v("bottom_swap", 16'h0000, {13'h0, seen_hs});
    cnt_win(160, di, d0, d1);
    chk_n("zero_cur", 0, d1);
    chk_n("zero_top", 2, d0);
    repeat (8)
    begin
      set_cmp(rv(), rv(), rv(), rv(), rv());
      repeat (100) @(posedge clk);
    end
    #1;
    oc_req = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_v("oc_irq", 16'h0001, {15'h0, oc_irq});
    chk_v("fault", 16'h0001, {15'h0, fault});
    fault_clr = 1'b1;
    @(posedge clk);
    #1;
    fault_clr = 1'b0;
    chk_v("gates_off", 16'h0000, {10'h0, hs, ls});
    chk_v("fault_hold", 16'h0001, {15'h0, fault});
    cnt_win(160, di, d0, d1);
    chk_n("fault_irq", 0, di);
    oc_req = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    fault_clr = 1'b1;
    @(posedge clk);
    #1;
    fault_clr = 1'b0;
    chk_v("fault_clr", 16'h0000, {15'h0, fault});
    repeat (100) @(posedge clk);
    #1;
    run_req = 1'b0;
    repeat (20) @(posedge clk);
    seen_hs = 3'h0;
    seen_ls = 3'h0;
    cnt_win(160, di, d0, d1);
    chk_n("stop_irq", 0, di);
    chk_v("stop_gates", 16'h0000, {10'h0, seen_hs, seen_ls});
    results();
  end
endmodule
